// *** pkg/bsid_consts.svh ***
`ifndef BSID_CONSTS_SVH
`define BSID_CONSTS_SVH
`define BSID_IR_W 10
`define BSID_OP_SAMPLE 10'h005
`define BSID_OP_EXTEST 10'h00F
`define BSID_OP_BYPASS 10'h3FF
`define BSID_OP_USERCODE 10'h007
`define BSID_OP_IDCODE 10'h006
`define BSID_OP_HIGHZ 10'h00B
`define BSID_OP_CLAMP 10'h00A
`define BSID_OP_RECONFIG 10'h001
`define BSID_OP_INCIRC_LO 10'h002
`define BSID_OP_INCIRC_HI 10'h004
`define BSID_IR_CAPTURE 10'h001
`define BSID_BSR_W 8
`define BSID_ID_W 32
`define BSID_USER_RESET 32'h0000_0000
`define BSID_IDCODE_VAL 32'h1234_5679
`define BSID_RECONF_CYC 4
`endif

// *** pkg/bsid_pkg.sv ***
package bsid_pkg;
	typedef enum logic [1:0] {
		BSID_SEL_BYPASS,
		BSID_SEL_BSR,
		BSID_SEL_USER,
		BSID_SEL_ID
	} bsid_sel_t;
	typedef enum {
		BSID_TLR, BSID_RTI, BSID_SELDR, BSID_CAPDR, BSID_SHDR, BSID_EX1DR, BSID_PADR,
		BSID_EX2DR, BSID_UPDR, BSID_SELIR, BSID_CAPIR, BSID_SHIR, BSID_EX1IR, BSID_PAIR,
		BSID_EX2IR, BSID_UPIR
	} bsid_tap_t;
endpackage

// *** verilog/bsid_sync.sv ***
`timescale 1ns/10ps
// Two-stage synchroniser for the test pins; first stage feeds only the second
module bsid_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic [2:0] asyncIn,
	output logic [2:0] syncOut
);
	logic [2:0] meta_q;
	logic [2:0] meta_d;
	logic [2:0] sync_q;
	logic [2:0] sync_d;
	always_comb begin
		meta_d = asyncIn;
		sync_d = meta_q;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q <= 3'h0;
			sync_q <= 3'h0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign syncOut = sync_q;
endmodule // bsid_sync

// *** verilog/bsid_decoder.sv ***
`timescale 1ns/10ps
`include "bsid_consts.svh"
// Summary of operation
// - Sample/preload: capture pins into scan register, pins stay in normal mode.
// - Extest: drive scan register onto pins, capture input pins.
// - All-ones code: one-bit bypass between data in and data out.
// - User code: shift 32-bit user code register out.
// - Identification: shift identification register out.
// - High-Z: bypass path, all user pins tri-stated.
// - Clamp: bypass path, pins held at scan register update values.
// - Reconfig trigger: pulse internal restart as if restart pin went low.
// - In-circuit reconfiguration codes are accepted and flagged to configuration logic.
module bsid_decoder (
	input wire logic clk,
	input wire logic reset,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdoEn,
	input wire logic [`BSID_BSR_W-1:0] corePinOut,
	input wire logic [`BSID_BSR_W-1:0] corePinOe,
	input wire logic [`BSID_BSR_W-1:0] pinIn,
	output logic [`BSID_BSR_W-1:0] pinOut,
	output logic [`BSID_BSR_W-1:0] pinOe,
	input wire logic [`BSID_ID_W-1:0] userCode,
	output logic reconfigTrigger,
	output logic inCircuitReconfig,
	output logic [`BSID_IR_W-1:0] instrOut
);
	logic [2:0] pinSync;
	logic tckS, tmsS, tdiS, tckPrev_q, tckRise, tckFall;
	bsid_pkg::bsid_tap_t tap_q, tap_d;
	logic [`BSID_IR_W-1:0] irShift_q, irShift_d, ir_q, ir_d;
	logic [`BSID_BSR_W-1:0] bsrShift_q, bsrShift_d, bsrUpd_q, bsrUpd_d;
	logic [`BSID_BSR_W-1:0] pinMeta_q, pinMeta_d, pinHold_q, pinHold_d;
	logic [`BSID_ID_W-1:0] drShift_q, drShift_d;
	logic byp_q, byp_d, tdo_q, tdo_d, tdoEn_q, tdoEn_d;
	logic [2:0] reconfCnt_q, reconfCnt_d;
	bsid_pkg::bsid_sel_t sel;

	bsid_sync uSync (
		.clk(clk),
		.reset(reset),
		.asyncIn({tck, tms, tdi}),
		.syncOut(pinSync)
	);
	assign tckS = pinSync[2];
	assign tmsS = pinSync[1];
	assign tdiS = pinSync[0];
	assign tckRise = tckS & ~tckPrev_q;
	assign tckFall = ~tckS & tckPrev_q;

	// Undefined codes decode to the bypass register
	function automatic bsid_pkg::bsid_sel_t selOf(input logic [`BSID_IR_W-1:0] op);
		if (op == `BSID_OP_SAMPLE || op == `BSID_OP_EXTEST)
			return bsid_pkg::BSID_SEL_BSR;
		else if (op == `BSID_OP_USERCODE)
			return bsid_pkg::BSID_SEL_USER;
		else if (op == `BSID_OP_IDCODE)
			return bsid_pkg::BSID_SEL_ID;
		else
			return bsid_pkg::BSID_SEL_BYPASS;
	endfunction
	assign sel = selOf(ir_q);

	always_comb begin
		tap_d = tap_q;
		if (tckRise) begin
			case (tap_q)
				bsid_pkg::BSID_TLR: tap_d = tmsS ? bsid_pkg::BSID_TLR : bsid_pkg::BSID_RTI;
				bsid_pkg::BSID_RTI: tap_d = tmsS ? bsid_pkg::BSID_SELDR : bsid_pkg::BSID_RTI;
				bsid_pkg::BSID_SELDR: tap_d = tmsS ? bsid_pkg::BSID_SELIR : bsid_pkg::BSID_CAPDR;
				bsid_pkg::BSID_CAPDR: tap_d = tmsS ? bsid_pkg::BSID_EX1DR : bsid_pkg::BSID_SHDR;
				bsid_pkg::BSID_SHDR: tap_d = tmsS ? bsid_pkg::BSID_EX1DR : bsid_pkg::BSID_SHDR;
				bsid_pkg::BSID_EX1DR: tap_d = tmsS ? bsid_pkg::BSID_UPDR : bsid_pkg::BSID_PADR;
				bsid_pkg::BSID_PADR: tap_d = tmsS ? bsid_pkg::BSID_EX2DR : bsid_pkg::BSID_PADR;
				bsid_pkg::BSID_EX2DR: tap_d = tmsS ? bsid_pkg::BSID_UPDR : bsid_pkg::BSID_SHDR;
				bsid_pkg::BSID_UPDR: tap_d = tmsS ? bsid_pkg::BSID_SELDR : bsid_pkg::BSID_RTI;
				bsid_pkg::BSID_SELIR: tap_d = tmsS ? bsid_pkg::BSID_TLR : bsid_pkg::BSID_CAPIR;
				bsid_pkg::BSID_CAPIR: tap_d = tmsS ? bsid_pkg::BSID_EX1IR : bsid_pkg::BSID_SHIR;
				bsid_pkg::BSID_SHIR: tap_d = tmsS ? bsid_pkg::BSID_EX1IR : bsid_pkg::BSID_SHIR;
				bsid_pkg::BSID_EX1IR: tap_d = tmsS ? bsid_pkg::BSID_UPIR : bsid_pkg::BSID_PAIR;
				bsid_pkg::BSID_PAIR: tap_d = tmsS ? bsid_pkg::BSID_EX2IR : bsid_pkg::BSID_PAIR;
				bsid_pkg::BSID_EX2IR: tap_d = tmsS ? bsid_pkg::BSID_UPIR : bsid_pkg::BSID_SHIR;
				bsid_pkg::BSID_UPIR: tap_d = tmsS ? bsid_pkg::BSID_SELDR : bsid_pkg::BSID_RTI;
				default: tap_d = bsid_pkg::BSID_TLR;
			endcase
		end
	end

	always_comb begin
		// Pin levels are asynchronous to clk, so they pass two stages before capture
		pinMeta_d = pinIn;
		pinHold_d = pinMeta_q;
		irShift_d = irShift_q;
		ir_d = ir_q;
		bsrShift_d = bsrShift_q;
		bsrUpd_d = bsrUpd_q;
		drShift_d = drShift_q;
		byp_d = byp_q;
		tdo_d = tdo_q;
		tdoEn_d = tdoEn_q;
		if (tckRise) begin
			case (tap_q)
				bsid_pkg::BSID_TLR: ir_d = `BSID_OP_IDCODE;
				bsid_pkg::BSID_CAPIR: irShift_d = `BSID_IR_CAPTURE;
				bsid_pkg::BSID_SHIR: irShift_d = {tdiS, irShift_q[`BSID_IR_W-1:1]};
				bsid_pkg::BSID_CAPDR: begin
					byp_d = 1'b0;
					bsrShift_d = pinHold_q;
					if (sel == bsid_pkg::BSID_SEL_USER)
						drShift_d = userCode;
					else
						drShift_d = `BSID_IDCODE_VAL;
				end
				bsid_pkg::BSID_SHDR: begin
					byp_d = tdiS;
					bsrShift_d = {tdiS, bsrShift_q[`BSID_BSR_W-1:1]};
					drShift_d = {tdiS, drShift_q[`BSID_ID_W-1:1]};
				end
				bsid_pkg::BSID_UPDR: begin
					// Preload and extest both latch the pattern; clamp then reuses it
					if (sel == bsid_pkg::BSID_SEL_BSR)
						bsrUpd_d = bsrShift_q;
				end
				bsid_pkg::BSID_UPIR: ir_d = irShift_q;
				default: ;
			endcase
		end
		// Data out changes on the falling edge, as the standard demands
		if (tckFall) begin
			tdoEn_d = (tap_q == bsid_pkg::BSID_SHDR) || (tap_q == bsid_pkg::BSID_SHIR);
			if (tap_q == bsid_pkg::BSID_SHIR)
				tdo_d = irShift_q[0];
			else if (sel == bsid_pkg::BSID_SEL_BSR)
				tdo_d = bsrShift_q[0];
			else if (sel == bsid_pkg::BSID_SEL_BYPASS)
				tdo_d = byp_q;
			else
				tdo_d = drShift_q[0];
		end
	end

	always_comb begin
		reconfCnt_d = reconfCnt_q;
		if (tckRise && tap_q == bsid_pkg::BSID_UPIR && irShift_q == `BSID_OP_RECONFIG)
			reconfCnt_d = 3'(`BSID_RECONF_CYC);
		else if (reconfCnt_q != 3'h0)
			reconfCnt_d = reconfCnt_q - 3'h1;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			tckPrev_q <= 1'b0;
			tap_q <= bsid_pkg::BSID_TLR;
			irShift_q <= 10'h000;
			ir_q <= `BSID_OP_IDCODE;
			bsrShift_q <= 8'h00;
			bsrUpd_q <= 8'h00;
			pinMeta_q <= 8'h00;
			pinHold_q <= 8'h00;
			drShift_q <= 32'h0000_0000;
			byp_q <= 1'b0;
			tdo_q <= 1'b0;
			tdoEn_q <= 1'b0;
			reconfCnt_q <= 3'h0;
		end else begin
			tckPrev_q <= tckS;
			tap_q <= tap_d;
			irShift_q <= irShift_d;
			ir_q <= ir_d;
			bsrShift_q <= bsrShift_d;
			bsrUpd_q <= bsrUpd_d;
			pinMeta_q <= pinMeta_d;
			pinHold_q <= pinHold_d;
			drShift_q <= drShift_d;
			byp_q <= byp_d;
			tdo_q <= tdo_d;
			tdoEn_q <= tdoEn_d;
			reconfCnt_q <= reconfCnt_d;
		end
	end

	// Pin muxing: the core keeps the pins except under extest, high-Z and clamp
	always_comb begin
		pinOut = corePinOut;
		pinOe = corePinOe;
		if (ir_q == `BSID_OP_EXTEST || ir_q == `BSID_OP_CLAMP) begin
			pinOut = bsrUpd_q;
			pinOe = {`BSID_BSR_W{1'b1}};
		end else if (ir_q == `BSID_OP_HIGHZ) begin
			pinOut = {`BSID_BSR_W{1'b0}};
			pinOe = {`BSID_BSR_W{1'b0}};
		end
	end

	assign tdo = tdo_q;
	assign tdoEn = tdoEn_q;
	assign reconfigTrigger = reconfCnt_q != 3'h0;
	// Only the restart request leaves the block; the real restart pin is untouched
	assign inCircuitReconfig = ir_q >= `BSID_OP_INCIRC_LO && ir_q <= `BSID_OP_INCIRC_HI
		&& ir_q != `BSID_OP_SAMPLE;
	assign instrOut = ir_q;
endmodule // bsid_decoder

// *** test/bsid_monitor.sv ***
`timescale 1ns/10ps
module bsid_monitor (
	input wire logic clk,
	input wire logic reset,
	input wire logic tdoEn,
	input wire logic [7:0] corePinOut,
	input wire logic [7:0] pinOut,
	input wire logic [7:0] pinOe,
	input wire logic reconfigTrigger,
	input wire logic inCircuitReconfig,
	input wire logic [9:0] instrOut
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (reset);
	sample_pins_a: assert property (instrOut == 10'h005 |-> pinOut == corePinOut)
		else $error("sample mode changed pins");
	extest_drive_a: assert property (instrOut == 10'h00F |-> pinOe == 8'hFF)
		else $error("extest not driving");
	hiz_pins_a: assert property (instrOut == 10'h00B |-> pinOe == 8'h00)
		else $error("highz pin driven");
	clamp_hold_a: assert property ($stable(instrOut) && instrOut == 10'h00A |->
		$stable(pinOut))
		else $error("clamp pins moved");
	reconf_pulse_a: assert property ($rose(reconfigTrigger) |->
		reconfigTrigger[*4] ##1 !reconfigTrigger)
		else $error("restart pulse length wrong");
	incircuit_flag_a: assert property (inCircuitReconfig ==
		(instrOut inside {10'h002, 10'h003, 10'h004}))
		else $error("reconfig flag wrong");
	reset_instr_a: assert property ($fell(reset) |-> instrOut == 10'h006)
		else $error("reset instruction wrong");
	instr_hold_a: assert property (tdoEn |-> $stable(instrOut))
		else $error("instruction changed while shifting");
	cover property ($rose(reconfigTrigger));
	cover property (instrOut == 10'h00B);
	cover property (instrOut == 10'h00F);
endmodule // bsid_monitor
bind bsid_decoder bsid_monitor mon_u (.clk(clk), .reset(reset), .tdoEn(tdoEn),
	.corePinOut(corePinOut), .pinOut(pinOut), .pinOe(pinOe), .reconfigTrigger(reconfigTrigger),
	.inCircuitReconfig(inCircuitReconfig), .instrOut(instrOut));

// *** test/bsid_tester.sv ***
`timescale 1ns/10ps
module bsid_tester (
	input wire logic clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial {tck, tms, tdi} = 3'b010;
	// Test clock idles low between steps; each half period is four system clocks
	// Data out is taken just before the rise, four clocks after the previous fall launched it
	task step(input logic m, d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		o = tdo;
		tck <= 1'b1;
		repeat (4) @(posedge clk);
		tck <= 1'b0;
	endtask
endmodule // bsid_tester

// *** test/boundary_scan_instruction_decoder_tb.sv ***
`timescale 1ns/10ps
`include "bsid_consts.svh"
module boundary_scan_instruction_decoder_tb;
	logic clk = 0, reset = 1, tck, tms, tdi, tdo, tdoEn, reconfigTrigger, inCircuitReconfig, o;
	logic [7:0] corePinOut = 0, corePinOe = 0, pinIn = 0, pinOut, pinOe, pat;
	logic [31:0] userCode = 0, rd;
	logic [9:0] instrOut, code;
	int failures = 0, compares = 0, rcCnt = 0;
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (reconfigTrigger) rcCnt <= rcCnt + 1;
	bsid_tester tst_u (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	bsid_decoder dut_u (.clk(clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdoEn(tdoEn), .corePinOut(corePinOut), .corePinOe(corePinOe), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .userCode(userCode), .reconfigTrigger(reconfigTrigger),
		.inCircuitReconfig(inCircuitReconfig), .instrOut(instrOut));
	task chk(input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task ir(input logic [9:0] c);
		for (int i = 0; i < 4; i++) tst_u.step(i < 2, 0, o);
		for (int i = 0; i < 10; i++) tst_u.step(i == 9, c[i], o);
		tst_u.step(1, 0, o);
		tst_u.step(0, 0, o);
		chk(instrOut, c);
		$display("instruction %h done", c);
	endtask
	// Pins as the rules want them outside high-Z: core drive unless extest or clamp takes them over
	function automatic logic [15:0] expPins(input logic [9:0] op, input logic [7:0] upd);
		if (op == `BSID_OP_EXTEST || op == `BSID_OP_CLAMP)
			return {8'hFF, upd};
		return {corePinOe, corePinOut};
	endfunction
	// Bit i of the captured value stands on data out before the i-th shifting rise
	task dr(input int n, input logic [31:0] din);
		rd = 0;
		tst_u.step(1, 0, o);
		tst_u.step(0, 0, o);
		tst_u.step(0, 0, o);
		for (int i = 0; i < n; i++) begin
			tst_u.step(i == n - 1, din[i], o);
			rd[i] = o;
		end
		tst_u.step(1, 0, o);
		tst_u.step(0, 0, o);
	endtask
	task give_verdict;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h21A0));
		repeat (2) @(posedge clk);
		reset <= 0;
		repeat (4) @(posedge clk);
		tst_u.step(0, 0, o);
		chk(instrOut, `BSID_OP_IDCODE);
		dr(32, 0);
		chk(rd, `BSID_IDCODE_VAL);
		$display("identification test done");
		userCode <= $urandom;
		pinIn <= 8'($urandom);
		corePinOut <= 8'($urandom);
		corePinOe <= 8'($urandom);
		pat = 8'($urandom);
		ir(`BSID_OP_SAMPLE);
		chk({pinOe, pinOut}, expPins(`BSID_OP_SAMPLE, pat));
		dr(8, pat);
		chk(rd[7:0], pinIn);
		chk({pinOe, pinOut}, expPins(`BSID_OP_SAMPLE, pat));
		ir(`BSID_OP_EXTEST);
		chk({pinOe, pinOut}, expPins(`BSID_OP_EXTEST, pat));
		pinIn <= 8'($urandom);
		pat = 8'($urandom);
		dr(8, pat);
		chk(rd[7:0], pinIn);
		chk({pinOe, pinOut}, expPins(`BSID_OP_EXTEST, pat));
		ir(`BSID_OP_CLAMP);
		chk({pinOe, pinOut}, expPins(`BSID_OP_CLAMP, pat));
		dr(2, 32'h1);
		chk(rd[1:0], 2'b10);
		chk({pinOe, pinOut}, expPins(`BSID_OP_CLAMP, pat));
		ir(`BSID_OP_HIGHZ);
		chk(pinOe, 0);
		ir(`BSID_OP_USERCODE);
		dr(32, 0);
		chk(rd, userCode);
		$display("user code test done");
		// Bit 8 set keeps the random code clear of every defined instruction but all-ones
		code = 10'h100 | 10'($urandom);
		for (int k = 0; k < 4; k++) begin
			ir(k == 0 ? `BSID_OP_BYPASS : k == 1 ? 10'h155 : k == 2 ? code : `BSID_OP_HIGHZ);
			dr(2, 32'h1);
			chk(rd[1:0], 2'b10);
		end
		$display("bypass test done");
		for (int c = 2; c < 5; c++) begin
			ir(10'(c));
			chk(inCircuitReconfig, 1);
		end
		ir(`BSID_OP_RECONFIG);
		chk(inCircuitReconfig, 0);
		repeat (8) @(posedge clk);
		chk(rcCnt, 4);
		$display("reconfiguration test done");
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		repeat (4) @(posedge clk);
		chk(instrOut, `BSID_OP_IDCODE);
		chk({pinOe, pinOut}, expPins(`BSID_OP_IDCODE, pat));
		$display("mid-run reset test done");
		give_verdict;
	end
endmodule // boundary_scan_instruction_decoder_tb
